// File: smd_angle.v
// Electrical angle counter with direction and initial-position load.
`timescale 1ns/1ps
`default_nettype none
`include "smd_defs.vh"
module smd_angle #(
   parameter W = `SMD_ANGLE_W
) (
   input wire aclk,
   input wire aresetn,
   input wire clear,
   input wire load_init,
   input wire step,
   input wire dir_cw,
   output reg [W-1:0] angle_reg,
   output wire at_init
);
   reg [W-1:0] angle_next;
   always @* begin
      angle_next = angle_reg;
      if (clear || load_init) begin
         angle_next = `SMD_INIT_ANGLE;
      end else if (step) begin
         // A leads B when counting up; B leads A when counting down.
         if (dir_cw) begin
            angle_next = angle_reg + {{(W-1){1'b0}}, 1'b1};
         end else begin
            angle_next = angle_reg - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         angle_reg <= `SMD_INIT_ANGLE;
      end else begin
         angle_reg <= angle_next;
      end
   end
   assign at_init = (angle_reg == `SMD_INIT_ANGLE);
endmodule // smd_angle
`default_nettype wire

// File: smd_chk.sv
// Concurrent checks on the pins and bus of the stepper drive mode control block.
`timescale 1ns/1ps
`default_nettype none
module smd_chk #(
   parameter SETTLE_CYC = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic standby_n_input,
   input wire logic enable_in,
   input wire logic start_in,
   input wire logic vbat_uv_in,
   input wire logic internal_5v_rail_uv_in,
   input wire logic phase_oe_n,
   input wire logic system_oscillator_en,
   input wire logic pwm_oscillator_en,
   input wire logic angle_init_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   stby_osc_a: assert property ((!standby_n_input)[*5] |-> !system_oscillator_en && !pwm_oscillator_en) else $error("oscillators run in standby");
   stby_hiz_a: assert property ((!standby_n_input)[*6] |-> phase_oe_n) else $error("phases driven in standby");
   en_hiz_a: assert property ((!enable_in)[*6] |-> phase_oe_n) else $error("phases driven with enable low");
   vbat_hiz_a: assert property (vbat_uv_in[*6] |-> phase_oe_n) else $error("phases driven in battery undervoltage");
   rail_reset_a: assert property (internal_5v_rail_uv_in[*4] |-> phase_oe_n && !angle_init_n && !system_oscillator_en) else $error("rail undervoltage left logic running");
   init_hold_a: assert property (start_in[*6] |-> !angle_init_n) else $error("angle left initial position with start high");
   osc_run_a: assert property ((standby_n_input && !internal_5v_rail_uv_in)[*8] |-> system_oscillator_en && pwm_oscillator_en) else $error("oscillators stopped in active mode");
   settle_off_a: assert property ($rose(system_oscillator_en) |-> phase_oe_n[*8]) else $error("phases driven while rail settles");
   wr_resp_a: assert property (wr_taken |=> s_axi_bvalid) else $error("write response late");
   rd_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read response late");
endmodule // smd_chk
bind smd_top smd_chk #(.SETTLE_CYC(SETTLE_CYC)) smd_chk_i (.aclk, .aresetn, .standby_n_input,
   .enable_in, .start_in, .vbat_uv_in, .internal_5v_rail_uv_in, .phase_oe_n, .system_oscillator_en,
   .pwm_oscillator_en, .angle_init_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// File: smd_defs.vh
// Constants for the stepper drive mode control block.
`ifndef SMD_DEFS_VH
`define SMD_DEFS_VH
`define SMD_CLK_HZ 100000000
`define SMD_SETTLE_US 500
`define SMD_SETTLE_CYC ((`SMD_SETTLE_US * (`SMD_CLK_HZ / 1000000)))
`define SMD_ANGLE_W 7
`define SMD_INIT_ANGLE 7'h08
`define SMD_MODE_STBY 3'h0
`define SMD_MODE_SETTLE 3'h1
`define SMD_MODE_OFF 3'h2
`define SMD_MODE_INIT 3'h3
`define SMD_MODE_RUN 3'h4
`define SMD_ADDR_CTRL 4'h0
`define SMD_ADDR_STAT 4'h4
`define SMD_ADDR_ANGLE 4'h8
`define SMD_CTRL_RESET 3'h0
`endif

// File: smd_host.sv
// Host-side pin driver model for the stepper drive mode control block.
`timescale 1ns/1ps
`default_nettype none
module smd_host (
   input wire logic aclk,
   input wire logic [5:0] lvl,
   input wire logic step_go,
   input wire logic [7:0] step_n,
   output logic [5:0] pins,
   output logic step_clk,
   output logic busy
);
   logic [7:0] cnt_reg = 8'h00;
   logic [2:0] ph_reg = 3'h0;
   // Four cycles low then four high keeps each step level well above the sync window.
   assign step_clk = (cnt_reg != 8'h00) && ph_reg[2];
   assign busy = (cnt_reg != 8'h00);
   always @(posedge aclk) begin
      pins <= lvl;
      if (step_go) begin
         cnt_reg <= step_n;
         ph_reg <= 3'h0;
      end else if (cnt_reg != 8'h00) begin
         ph_reg <= ph_reg + 3'h1;
         if (ph_reg == 3'h7) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
endmodule // smd_host
`default_nettype wire

// File: smd_sync.v
// Two-flop synchroniser bank with combinational rising-edge detect on bit 0.
`timescale 1ns/1ps
`default_nettype none
module smd_sync #(
   parameter W = 6
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out,
   output wire rise0
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   reg last0_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
         last0_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last0_reg <= sync_reg[0];
      end
   end
   assign sync_out = sync_reg;
   assign rise0 = sync_reg[0] & ~last0_reg;
endmodule // smd_sync
`default_nettype wire

// File: smd_top.v
// Stepper drive mode control: pin gating, mode choice and AXI4-Lite status.
`timescale 1ns/1ps
`default_nettype none
`include "smd_defs.vh"
module smd_top #(
   parameter SETTLE_CYC = `SMD_SETTLE_CYC,
   parameter ANGLE_W = `SMD_ANGLE_W
) (
   input wire aclk,
   input wire aresetn,
   input wire standby_n_input,
   input wire enable_in,
   input wire start_in,
   input wire direction_select,
   input wire step_clk_in,
   input wire vbat_uv_in,
   input wire internal_5v_rail_uv_in,
   output wire phase_a_pos_out,
   output wire phase_a_neg_out,
   output wire phase_b_pos_out,
   output wire phase_b_neg_out,
   output wire phase_oe_n,
   output wire system_oscillator_en,
   output wire pwm_oscillator_en,
   output wire angle_init_n,
   input wire [3:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   // ****************************************
   // Input synchronisation
   // ****************************************
   wire [5:0] pins_sync;
   wire step_rise;
   wire uv_rail_sync;
   wire rst_ok;
   smd_sync #(.W(6)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({internal_5v_rail_uv_in, vbat_uv_in, direction_select, start_in,
                 enable_in, step_clk_in}),
      .sync_out(pins_sync),
      .rise0(step_rise)
   );
   wire en_s = pins_sync[1];
   wire start_s = pins_sync[2];
   wire dir_s = pins_sync[3];
   wire vbat_uv_s = pins_sync[4];
   assign uv_rail_sync = pins_sync[5];
   // Rail undervoltage acts as a logic-wide reset of all control state.
   assign rst_ok = aresetn & ~uv_rail_sync;

   // ****************************************
   // Mode state machine
   // ****************************************
   reg standby_sync1_reg;
   reg standby_sync_reg;
   reg [2:0] mode_reg;
   reg [2:0] mode_next;
   reg [31:0] settle_reg;
   reg [31:0] settle_next;
   reg [2:0] ctrl_reg;
   wire force_hiz = ctrl_reg[0];
   wire hold_init = ctrl_reg[1];

   always @(posedge aclk) begin
      if (!rst_ok) begin
         standby_sync1_reg <= 1'b0;
         standby_sync_reg <= 1'b0;
      end else begin
         standby_sync1_reg <= standby_n_input;
         standby_sync_reg <= standby_sync1_reg;
      end
   end

   always @* begin
      mode_next = mode_reg;
      settle_next = settle_reg;
      if (!standby_sync_reg) begin
         // Standby wins over every other pin, enable included.
         mode_next = `SMD_MODE_STBY;
         settle_next = 32'h0;
      end else begin
         case (mode_reg)
            `SMD_MODE_STBY: begin
               mode_next = `SMD_MODE_SETTLE;
               settle_next = 32'h0;
            end
            `SMD_MODE_SETTLE: begin
               // The internal rail needs time to settle; phase outputs stay off meanwhile.
               if (settle_reg >= SETTLE_CYC - 1) begin
                  mode_next = `SMD_MODE_OFF;
               end else begin
                  settle_next = settle_reg + 32'h1;
               end
            end
            `SMD_MODE_OFF, `SMD_MODE_INIT, `SMD_MODE_RUN: begin
               if (!en_s) begin
                  mode_next = `SMD_MODE_OFF;
               end else if (start_s) begin
                  mode_next = `SMD_MODE_INIT;
               end else begin
                  mode_next = `SMD_MODE_RUN;
               end
            end
            default: begin
               mode_next = `SMD_MODE_STBY;
            end
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!rst_ok) begin
         mode_reg <= `SMD_MODE_STBY;
         settle_reg <= 32'h0;
      end else begin
         mode_reg <= mode_next;
         settle_reg <= settle_next;
      end
   end

   wire in_standby = (mode_reg == `SMD_MODE_STBY);
   wire logic_live = ~in_standby & (mode_reg != `SMD_MODE_SETTLE);
   assign system_oscillator_en = ~in_standby;
   assign pwm_oscillator_en = ~in_standby;

   // ****************************************
   // Electrical angle
   // ****************************************
   // Steps count outside standby and settle whenever start and hold_init are low, also with enable low, and also
   // under battery undervoltage since inputs keep being accepted.
   wire step_ok = step_rise & logic_live & ~start_s & ~hold_init;
   wire load_init = logic_live & (start_s | hold_init);
   wire [ANGLE_W-1:0] angle;
   wire at_init;
   smd_angle #(.W(ANGLE_W)) u_angle (
      .aclk(aclk),
      .aresetn(rst_ok),
      .clear(in_standby),
      .load_init(load_init),
      .step(step_ok),
      .dir_cw(dir_s),
      .angle_reg(angle),
      .at_init(at_init)
   );
   assign angle_init_n = ~at_init;

   // ****************************************
   // Phase outputs
   // ****************************************
   reg drive_reg;
   reg [3:0] phase_reg;
   // Quadrant of the electrical angle. Phase A follows the toggle of the low quadrant bit,
   // so counting up moves A one quadrant ahead of B and counting down moves B ahead.
   wire quad_hi = angle[ANGLE_W-1];
   wire quad_lo = angle[ANGLE_W-2];
   wire a_pol = quad_hi ^ quad_lo;
   wire b_pol = quad_hi;
   always @(posedge aclk) begin
      if (!rst_ok) begin
         drive_reg <= 1'b0;
         phase_reg <= 4'h0;
      end else begin
         drive_reg <= ((mode_reg == `SMD_MODE_RUN) | (mode_reg == `SMD_MODE_INIT))
                      & ~vbat_uv_s & ~force_hiz;
         // Quadrant bits give bridge polarity; B lags A by one quadrant when counting up and leads it when counting down.
         phase_reg <= {a_pol, ~a_pol,
                       b_pol, ~b_pol};
      end
   end
   assign phase_oe_n = ~drive_reg;
   assign phase_a_pos_out = phase_reg[3];
   assign phase_a_neg_out = phase_reg[2];
   assign phase_b_pos_out = phase_reg[1];
   assign phase_b_neg_out = phase_reg[0];

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   reg aw_got_reg;
   reg w_got_reg;
   reg [3:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg wstrb0_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [1:0] rresp_reg;
   reg [31:0] rdata_reg;
   assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   wire aw_now = aw_got_reg | s_axi_awvalid;
   wire w_now = w_got_reg | s_axi_wvalid;
   wire [3:0] wa = aw_got_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wd = w_got_reg ? wdata_reg : s_axi_wdata;
   wire wr_fire = aw_now & w_now & ~bvalid_reg;

   always @(posedge aclk) begin
      if (!rst_ok) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h0;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         ctrl_reg <= `SMD_CTRL_RESET;
      end else begin
         if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            if (wa == `SMD_ADDR_CTRL) begin
               bresp_reg <= 2'h0;
               // A data word taken ahead of its address writes only if its own strobe allowed it.
               if (w_got_reg ? wstrb0_reg : s_axi_wstrb[0]) begin
                  ctrl_reg <= wd[2:0];
               end
            end else if (wa == `SMD_ADDR_STAT || wa == `SMD_ADDR_ANGLE) begin
               bresp_reg <= 2'h0;
            end else begin
               bresp_reg <= 2'h2;
            end
         end else begin
            if (s_axi_awvalid & s_axi_awready) begin
               aw_got_reg <= 1'b1;
               awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
               w_got_reg <= 1'b1;
               wdata_reg <= s_axi_wdata;
               // The strobe is kept with the data so a late address still sees it.
               wstrb0_reg <= s_axi_wstrb[0];
            end
            if (bvalid_reg & s_axi_bready) begin
               bvalid_reg <= 1'b0;
            end
         end
      end
   end

   always @(posedge aclk) begin
      if (!rst_ok) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= 2'h0;
         rdata_reg <= 32'h0;
      end else if (s_axi_arvalid & ~rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= 2'h0;
         case (s_axi_araddr)
            `SMD_ADDR_CTRL: rdata_reg <= {29'h0, ctrl_reg};
            `SMD_ADDR_STAT: rdata_reg <= {24'h0, at_init, drive_reg, vbat_uv_s,
                                          standby_sync_reg, en_s, mode_reg};
            `SMD_ADDR_ANGLE: rdata_reg <= {{(32-ANGLE_W){1'b0}}, angle};
            default: begin
               rdata_reg <= 32'h0;
               rresp_reg <= 2'h2;
            end
         endcase
      end else if (rvalid_reg & s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule // smd_top
`default_nettype wire

// File: tb.sv
// Testbench for the stepper drive mode control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [5:0] lvl = 6'h00;
   logic step_go = 1'b0;
   logic [7:0] step_n = 8'h00;
   logic [5:0] pins;
   logic step_clk, busy;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, oe_n, init_n;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] ph;
   wire [1:0] osc;
   int failures = 0;
   int check_count = 0;
   always #5 aclk = ~aclk;
   smd_host smd_host_i (.aclk(aclk), .lvl(lvl), .step_go(step_go), .step_n(step_n),
      .pins(pins), .step_clk(step_clk), .busy(busy));
   smd_top #(.SETTLE_CYC(8)) smd_top_i (.aclk(aclk), .aresetn(aresetn),
      .standby_n_input(pins[0]), .enable_in(pins[1]), .start_in(pins[2]),
      .direction_select(pins[3]), .step_clk_in(step_clk), .vbat_uv_in(pins[4]),
      .internal_5v_rail_uv_in(pins[5]), .phase_a_pos_out(ph[3]), .phase_a_neg_out(ph[2]),
      .phase_b_pos_out(ph[1]), .phase_b_neg_out(ph[0]), .phase_oe_n(oe_n),
      .system_oscillator_en(osc[0]), .pwm_oscillator_en(osc[1]), .angle_init_n(init_n),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task summarize;
      begin
         if (failures == 0 && check_count > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         check_count++;
         if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (1) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
         end
         bready <= 1'b0;
         chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
   endtask
   task rd(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         while (1) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
         end
         rready <= 1'b0;
         chk(nm, e, rdata & m);
         chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
   endtask
   // Pin order is rail, battery, direction, start, enable, standby_n.
   task pin(input logic [5:0] v);
      begin
         @(posedge aclk);
         lvl <= v;
         repeat (20) @(posedge aclk);
      end
   endtask
   task step(input logic [7:0] n);
      begin
         @(posedge aclk);
         step_n <= n;
         step_go <= 1'b1;
         @(posedge aclk);
         step_go <= 1'b0;
         @(posedge aclk);
         while (busy === 1'b1) @(posedge aclk);
         repeat (6) @(posedge aclk);
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd("ctrl", 4'h0, 32'h7, 32'h0, 2'h0);
      wr(4'h0, 32'h5, 2'h0);
      rd("ctrl", 4'h0, 32'h7, 32'h5, 2'h0);
      wr(4'h0, 32'h0, 2'h0);
      wr(4'hc, 32'h1, 2'h2);
      rd("unmapped", 4'hc, 32'hffffffff, 32'h0, 2'h2);
      pin(6'b000010);
      step(8'd3);
      rd("mode", 4'h4, 32'h7, 32'h0, 2'h0);
      rd("angle", 4'h8, 32'h7f, 32'h08, 2'h0);
      chk("osc", 32'h0, {30'h0, osc});
      chk("phase", 32'h5, {28'h0, ph});
      pin(6'b001011);
      rd("mode", 4'h4, 32'h47, 32'h44, 2'h0);
      chk("osc", 32'h3, {30'h0, osc});
      step(8'd5);
      rd("angle", 4'h8, 32'h7f, 32'h0d, 2'h0);
      pin(6'b000011);
      step(8'd2);
      rd("angle", 4'h8, 32'h7f, 32'h0b, 2'h0);
      pin(6'b001001);
      rd("mode", 4'h4, 32'h7, 32'h2, 2'h0);
      step(8'd3);
      rd("angle", 4'h8, 32'h7f, 32'h0e, 2'h0);
      pin(6'b001111);
      rd("mode", 4'h4, 32'h7, 32'h3, 2'h0);
      step(8'd2);
      rd("angle", 4'h8, 32'h7f, 32'h08, 2'h0);
      pin(6'b011011);
      rd("vbat", 4'h4, 32'h20, 32'h20, 2'h0);
      step(8'd1);
      rd("angle", 4'h8, 32'h7f, 32'h09, 2'h0);
      chk("oe_n", 32'h1, {31'h0, oe_n});
      pin(6'b101011);
      chk("init_n", 32'h0, {31'h0, init_n});
      pin(6'b001011);
      rd("angle", 4'h8, 32'h7f, 32'h08, 2'h0);
      pin(6'b000011);
      step(8'd9);
      rd("angle", 4'h8, 32'h7f, 32'h7f, 2'h0);
      chk("phase", 32'h6, {28'h0, ph});
      pin(6'b001011);
      step(8'd33);
      rd("angle", 4'h8, 32'h7f, 32'h20, 2'h0);
      chk("phase", 32'h9, {28'h0, ph});
      wr(4'h0, 32'h1, 2'h0);
      rd("drive", 4'h4, 32'h40, 32'h0, 2'h0);
      wr(4'h0, 32'h2, 2'h0);
      rd("angle", 4'h8, 32'h7f, 32'h08, 2'h0);
      rd("drive", 4'h4, 32'h40, 32'h40, 2'h0);
      summarize;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      summarize;
   end
endmodule // tb
`default_nettype wire
